// ==== rtl/zero_clamp_velocity_reach.sv ====
// Zero clamp and speed reach supervision with an Avalon-MM register slave.
`timescale 1ns/1ns
module zero_clamp_velocity_reach #(
	parameter int unsigned SPEED_WINDOW = zero_clamp_pkg::SPEED_WINDOW_CYCLES
) (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               srst,
	// Avalon-MM register slave
	input  wire logic [5:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	output logic      [31:0]        readdata,
	output logic                    waitrequest,
	// Velocity loop
	input  wire logic signed [15:0] velocity_command,
	input  wire logic signed [15:0] motor_velocity,
	input  wire logic [31:0]        motor_position,
	output logic signed [15:0]      effective_velocity_command,
	output logic                    hold_active,
	output logic [31:0]             hold_position,
	// Digital inputs and general outputs
	input  wire logic [7:0]         digital_inputs,
	input  wire logic               mode_switch_input,
	output logic [3:0]              general_outputs,
	// Command pulses
	input  wire logic               command_pulse,
	input  wire logic               command_pulse_dir,
	output logic [31:0]             pulse_position,
	output logic [15:0]             pulse_speed
);
	import zero_clamp_pkg::*;

	typedef struct packed {
		logic [3:0]         mode;
		logic               motor_linear;
		logic [2:0]         hold_pin;
		logic [13:0]        level_rot;
		logic [13:0]        level_lin;
		logic [6:0]         band_rot;
		logic [6:0]         band_lin;
		logic [1:0]         reach_pin;
		logic [15:0]        max_vel;
		bus_t               bus;
		logic [31:0]        rdata;
		clamp_t             clamp;
		logic [31:0]        hold_pos;
		logic signed [15:0] cmd_out;
		logic               reach;
		logic [3:0]         gout;
		logic [31:0]        pulse_pos;
		logic [15:0]        pulse_cnt;
		logic [15:0]        pulse_spd;
		logic [15:0]        win_cnt;
	} state_t;

	state_t      st;
	state_t      next_st;
	logic [16:0] cmd_mag;
	logic [16:0] meas_mag;
	logic [16:0] speed_diff;
	logic [13:0] level_sel;
	logic [15:0] level_eff;
	logic [6:0]  band_sel;
	logic        hold_at_zero_input;
	logic        mode_ok;
	logic        speed_reached_output;
	logic        window_end;

	// Magnitude with one extra bit so that the most negative value does not wrap.
	function automatic logic [16:0] magnitude(input logic signed [15:0] v);
		logic [16:0] ext;
		ext = {v[15], v};
		magnitude = v[15] ? 17'(17'h0 - ext) : ext;
	endfunction : magnitude

	function automatic logic [31:0] saturate(input logic [31:0] v, input logic [31:0] lim);
		saturate = (v > lim) ? lim : v;
	endfunction : saturate

	// In dual modes a low mode switch selects the first named half, high the second.
	function automatic logic clamp_mode_ok(input logic [3:0] mode, input logic sw);
		unique case (mode)
			MODE_VELOCITY, MODE_INTVEL, MODE_INTVEL_VEL:  clamp_mode_ok = 1'b1;
			MODE_INTVEL_POS, MODE_INTVEL_TRQ:             clamp_mode_ok = !sw;
			MODE_INTVEL_INTPOS:                           clamp_mode_ok = !sw;
			MODE_POS_VEL, MODE_TRQ_VEL, MODE_INTPOS_VEL:  clamp_mode_ok = sw;
			default:                                      clamp_mode_ok = 1'b0;
		endcase
	endfunction : clamp_mode_ok

	always_comb begin
		cmd_mag  = magnitude(velocity_command);
		meas_mag = magnitude(motor_velocity);
		level_sel = st.motor_linear ? st.level_lin : st.level_rot;
		band_sel  = st.motor_linear ? st.band_lin : st.band_rot;
		level_eff = ({2'b00, level_sel} > st.max_vel) ? st.max_vel : {2'b00, level_sel};
		speed_diff = (cmd_mag >= meas_mag) ? 17'(cmd_mag - meas_mag) : 17'(meas_mag - cmd_mag);
		speed_reached_output = (speed_diff <= {10'h000, band_sel});
		hold_at_zero_input = digital_inputs[st.hold_pin];
		mode_ok = clamp_mode_ok(st.mode, mode_switch_input);
		window_end = (st.win_cnt == 16'(SPEED_WINDOW - 1));
	end

	always_comb begin
		next_st = st;

		// Register slave: one wait cycle, the write lands on the acknowledging edge.
		unique case (st.bus)
			BUS_IDLE: begin
				if (read || write) begin
					next_st.bus = BUS_ACK;
					next_st.rdata = 32'h0000_0000;
					if (read) begin
						unique case (address)
							OFS_CONTROL: begin
								next_st.rdata[CTRL_MODE_LSB +: 4] = st.mode;
								next_st.rdata[CTRL_LINEAR_BIT] = st.motor_linear;
							end
							OFS_HOLD_PIN:  next_st.rdata = {29'h0, st.hold_pin};
							OFS_LEVEL_ROT: next_st.rdata = {18'h0, st.level_rot};
							OFS_LEVEL_LIN: next_st.rdata = {18'h0, st.level_lin};
							OFS_BAND_ROT:  next_st.rdata = {25'h0, st.band_rot};
							OFS_BAND_LIN:  next_st.rdata = {25'h0, st.band_lin};
							OFS_REACH_PIN: next_st.rdata = {30'h0, st.reach_pin};
							OFS_MAX_VEL:   next_st.rdata = {16'h0, st.max_vel};
							OFS_STATUS: begin
								next_st.rdata[STAT_HOLD_BIT] = (st.clamp == CLAMP_ON);
								next_st.rdata[STAT_REACH_BIT] = st.reach;
							end
							OFS_PULSE_POS: next_st.rdata = st.pulse_pos;
							OFS_PULSE_SPD: next_st.rdata = {16'h0, st.pulse_spd};
							default:       next_st.rdata = 32'h0000_0000;
						endcase
					end
				end
			end
			BUS_ACK: begin
				next_st.bus = BUS_IDLE;
				if (write) begin
					unique case (address)
						OFS_CONTROL: begin
							next_st.mode = writedata[CTRL_MODE_LSB +: 4];
							next_st.motor_linear = writedata[CTRL_LINEAR_BIT];
						end
						OFS_HOLD_PIN:  next_st.hold_pin = writedata[2:0];
						OFS_LEVEL_ROT: next_st.level_rot = 14'(saturate(writedata, 32'(LEVEL_MAX)));
						OFS_LEVEL_LIN: next_st.level_lin = 14'(saturate(writedata, 32'(LEVEL_MAX)));
						OFS_BAND_ROT:  next_st.band_rot = 7'(saturate(writedata, 32'(BAND_MAX)));
						OFS_BAND_LIN:  next_st.band_lin = 7'(saturate(writedata, 32'(BAND_MAX)));
						OFS_REACH_PIN: next_st.reach_pin = writedata[1:0];
						OFS_MAX_VEL:   next_st.max_vel = writedata[15:0];
						default:       next_st.max_vel = st.max_vel;
					endcase
				end
			end
		endcase

		// Equal magnitude keeps the present clamp state, which stops chatter at the level.
		if (!hold_at_zero_input || !mode_ok) begin
			next_st.clamp = CLAMP_OFF;
		end else begin
			unique case (st.clamp)
				CLAMP_OFF: begin
					if (cmd_mag < {1'b0, level_eff}) begin
						next_st.clamp = CLAMP_ON;
						next_st.hold_pos = motor_position;
					end
				end
				CLAMP_ON: begin
					if (cmd_mag > {1'b0, level_eff}) begin
						next_st.clamp = CLAMP_OFF;
					end
				end
			endcase
		end
		next_st.cmd_out = (next_st.clamp == CLAMP_ON) ? 16'sh0000 : velocity_command;

		next_st.reach = speed_reached_output;
		for (int i = 0; i < 4; i++) begin
			next_st.gout[i] = speed_reached_output && (st.reach_pin == 2'(i));
		end

		// Speed is pulses counted over one window; it lags the pulse train by a window.
		if (st.mode == MODE_POSITION) begin
			next_st.win_cnt = window_end ? 16'h0000 : 16'(st.win_cnt + 16'h0001);
			if (command_pulse) begin
				next_st.pulse_pos = command_pulse_dir ? 32'(st.pulse_pos - 32'h1)
						: 32'(st.pulse_pos + 32'h1);
			end
			if (window_end) begin
				next_st.pulse_spd = 16'(st.pulse_cnt + {15'h0, command_pulse});
				next_st.pulse_cnt = 16'h0000;
			end else if (command_pulse) begin
				next_st.pulse_cnt = 16'(st.pulse_cnt + 16'h0001);
			end
		end else begin
			next_st.win_cnt = 16'h0000;
			next_st.pulse_cnt = 16'h0000;
			next_st.pulse_spd = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
			st.mode <= RST_MODE;
			st.hold_pin <= RST_HOLD_PIN;
			st.level_rot <= RST_LEVEL;
			st.level_lin <= RST_LEVEL;
			st.band_rot <= RST_BAND;
			st.band_lin <= RST_BAND;
			st.reach_pin <= RST_REACH_PIN;
			st.max_vel <= RST_MAX_VEL;
			st.bus <= BUS_IDLE;
			st.clamp <= CLAMP_OFF;
		end else begin
			st <= next_st;
		end
	end

	assign waitrequest = (read || write) && (st.bus != BUS_ACK);
	assign readdata = st.rdata;
	assign effective_velocity_command = st.cmd_out;
	assign hold_active = (st.clamp == CLAMP_ON);
	assign hold_position = st.hold_pos;
	assign general_outputs = st.gout;
	assign pulse_position = st.pulse_pos;
	assign pulse_speed = st.pulse_spd;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_hold_engage;
		hold_at_zero_input && mode_ok && !hold_active && (cmd_mag < {1'b0, level_eff})
			|=> hold_active ##0 hold_position == $past(motor_position);
	endproperty
	a_hold_engage: assert property (p_hold_engage) else $error("clamp did not engage");

	property p_hold_zero;
		hold_active |-> effective_velocity_command == 16'sh0000;
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("command not held at zero");

	property p_hold_pos_stable;
		hold_active && $past(hold_active) |-> $stable(hold_position);
	endproperty
	a_hold_pos_stable: assert property (p_hold_pos_stable) else $error("hold moved");

	property p_release;
		hold_active && (cmd_mag > {1'b0, level_eff}) |=> !hold_active
			##0 effective_velocity_command == $past(velocity_command);
	endproperty
	a_release: assert property (p_release) else $error("clamp not released");

	property p_input_off;
		!hold_at_zero_input |=> !hold_active;
	endproperty
	a_input_off: assert property (p_input_off) else $error("clamp with input off");

	property p_mode_gate;
		!mode_ok |=> !hold_active;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("clamp in wrong mode");

	property p_level_cap;
		level_eff <= st.max_vel && level_eff <= {2'b00, level_sel};
	endproperty
	a_level_cap: assert property (p_level_cap) else $error("level not limited");

	property p_reach;
		!srst && (speed_diff <= {10'h000, band_sel}) |=> general_outputs[$past(st.reach_pin)];
	endproperty
	a_reach: assert property (p_reach) else $error("reach output missing");

	property p_no_reach;
		(speed_diff > {10'h000, band_sel}) |=> general_outputs == 4'h0;
	endproperty
	a_no_reach: assert property (p_no_reach) else $error("reach output spurious");

	// The reset edge is excluded because the outputs still hold their cleared values there.
	property p_reach_one_hot;
		!srst && (speed_diff <= {10'h000, band_sel})
			|=> general_outputs == 4'(4'h1 << $past(st.reach_pin));
	endproperty
	a_reach_one_hot: assert property (p_reach_one_hot) else $error("reach on wrong output");

	property p_cmd_pass;
		!srst && !hold_at_zero_input |=> effective_velocity_command == $past(velocity_command);
	endproperty
	a_cmd_pass: assert property (p_cmd_pass) else $error("command not passed through");

	property p_pulse_up;
		st.mode == MODE_POSITION && command_pulse && !command_pulse_dir
			|=> pulse_position == 32'($past(pulse_position) + 32'h1);
	endproperty
	a_pulse_up: assert property (p_pulse_up) else $error("pulse count wrong");

	property p_bus_one_wait;
		(read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus wait too long");
endmodule : zero_clamp_velocity_reach

// ==== rtl/zero_clamp_pkg.sv ====
// Constants, register map and types for the zero clamp and speed reach block.
package zero_clamp_pkg;
	localparam int unsigned CLK_FREQ_MHZ        = 50;
	localparam int unsigned SPEED_WINDOW_US     = 1000;
	localparam int unsigned SPEED_WINDOW_CYCLES = SPEED_WINDOW_US * CLK_FREQ_MHZ;

	localparam logic [5:0] OFS_CONTROL    = 6'h00;
	localparam logic [5:0] OFS_HOLD_PIN   = 6'h04;
	localparam logic [5:0] OFS_LEVEL_ROT  = 6'h08;
	localparam logic [5:0] OFS_LEVEL_LIN  = 6'h0C;
	localparam logic [5:0] OFS_BAND_ROT   = 6'h10;
	localparam logic [5:0] OFS_BAND_LIN   = 6'h14;
	localparam logic [5:0] OFS_REACH_PIN  = 6'h18;
	localparam logic [5:0] OFS_MAX_VEL    = 6'h1C;
	localparam logic [5:0] OFS_STATUS     = 6'h20;
	localparam logic [5:0] OFS_PULSE_POS  = 6'h24;
	localparam logic [5:0] OFS_PULSE_SPD  = 6'h28;

	localparam int unsigned CTRL_MODE_LSB    = 0;
	localparam int unsigned CTRL_LINEAR_BIT  = 4;
	localparam int unsigned STAT_HOLD_BIT    = 0;
	localparam int unsigned STAT_REACH_BIT   = 1;

	localparam logic [3:0]  RST_MODE      = 4'h0;
	localparam logic [2:0]  RST_HOLD_PIN  = 3'h0;
	localparam logic [13:0] RST_LEVEL     = 14'h000A;
	localparam logic [13:0] LEVEL_MAX     = 14'h2710;
	localparam logic [6:0]  RST_BAND      = 7'h0A;
	localparam logic [6:0]  BAND_MAX      = 7'h64;
	localparam logic [1:0]  RST_REACH_PIN = 2'h0;
	localparam logic [15:0] RST_MAX_VEL   = 16'h1770;

	localparam logic [3:0] MODE_VELOCITY      = 4'h0;
	localparam logic [3:0] MODE_POSITION      = 4'h1;
	localparam logic [3:0] MODE_INTVEL        = 4'h3;
	localparam logic [3:0] MODE_INTVEL_POS    = 4'h4;
	localparam logic [3:0] MODE_INTVEL_VEL    = 4'h5;
	localparam logic [3:0] MODE_INTVEL_TRQ    = 4'h6;
	localparam logic [3:0] MODE_POS_VEL       = 4'h7;
	localparam logic [3:0] MODE_TRQ_VEL       = 4'h9;
	localparam logic [3:0] MODE_INTPOS_VEL    = 4'hC;
	localparam logic [3:0] MODE_INTVEL_INTPOS = 4'hE;

	typedef enum logic {CLAMP_OFF = 1'b0, CLAMP_ON = 1'b1} clamp_t;
	typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_t;
endpackage : zero_clamp_pkg

// ==== bench/motion_ctrl_model.sv ====
// Behavioural motion controller that drives the velocity loop and the input pins.
`timescale 1ns/1ns
module motion_ctrl_model (
	// Clock
	input  wire logic          sys_clk,
	// Loop and pin signals towards the block
	output logic signed [15:0] velocity_command,
	output logic signed [15:0] motor_velocity,
	output logic [31:0]        motor_position,
	output logic [7:0]         digital_inputs,
	output logic               mode_switch_input,
	output logic               command_pulse,
	output logic               command_pulse_dir
);
	initial begin
		velocity_command = 16'h0000;
		motor_velocity = 16'h0000;
		motor_position = 32'h00000000;
		digital_inputs = 8'h00;
		mode_switch_input = 1'b0;
		command_pulse = 1'b0;
		command_pulse_dir = 1'b0;
	end

	// All loop inputs change together so the block never sees a half-updated set.
	task automatic drive(input logic [15:0] cmd, input logic [15:0] meas,
			input logic [7:0] pins, input logic sw, input logic [31:0] pos);
		@(posedge sys_clk);
		velocity_command <= cmd;
		motor_velocity <= meas;
		digital_inputs <= pins;
		mode_switch_input <= sw;
		motor_position <= pos;
	endtask : drive

	task automatic pulses(input int n, input logic dir);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			command_pulse <= 1'b1;
			command_pulse_dir <= dir;
		end
		@(posedge sys_clk);
		command_pulse <= 1'b0;
	endtask : pulses
endmodule : motion_ctrl_model

// ==== bench/tb_zero_clamp_velocity_reach.sv ====
// Self-checking bench for the zero clamp and speed reach block.
`timescale 1ns/1ns
module tb_zero_clamp_velocity_reach;
	import zero_clamp_pkg::*;
	localparam int SPEED_W = 16;
	logic               sys_clk, srst, read, write, waitrequest, hold_active;
	logic               mode_switch_input, command_pulse, command_pulse_dir;
	logic [5:0]         address;
	logic [31:0]        writedata, readdata, motor_position, hold_position, pulse_position;
	logic signed [15:0] velocity_command, motor_velocity, effective_velocity_command;
	logic [7:0]         digital_inputs;
	logic [3:0]         general_outputs;
	logic [15:0]        pulse_speed;
	int                 n_mismatch = 0;
	int                 check_count = 0;

	always #10 sys_clk = ~sys_clk;

	zero_clamp_velocity_reach #(.SPEED_WINDOW(SPEED_W)) i_zero_clamp_velocity_reach (
		.sys_clk(sys_clk), .srst(srst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.velocity_command(velocity_command), .motor_velocity(motor_velocity),
		.motor_position(motor_position),
		.effective_velocity_command(effective_velocity_command),
		.hold_active(hold_active), .hold_position(hold_position),
		.digital_inputs(digital_inputs), .mode_switch_input(mode_switch_input),
		.general_outputs(general_outputs), .command_pulse(command_pulse),
		.command_pulse_dir(command_pulse_dir), .pulse_position(pulse_position),
		.pulse_speed(pulse_speed));

	motion_ctrl_model i_motion_ctrl_model (
		.sys_clk(sys_clk), .velocity_command(velocity_command),
		.motor_velocity(motor_velocity), .motor_position(motor_position),
		.digital_inputs(digital_inputs), .mode_switch_input(mode_switch_input),
		.command_pulse(command_pulse), .command_pulse_dir(command_pulse_dir));

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// The request stands until an edge samples waitrequest low; data is taken there.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd_chk

	// Outputs are registered, so three edges cover input launch plus one cycle of latency.
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic drv(input logic [15:0] c, input logic [15:0] m, input logic [7:0] p,
			input logic s, input logic [31:0] pos);
		i_motion_ctrl_model.drive(c, m, p, s, pos);
		settle();
	endtask : drv

	task automatic t_defaults();
		rd_chk(OFS_CONTROL, 32'h0);
		rd_chk(OFS_LEVEL_ROT, 32'hA);
		rd_chk(OFS_LEVEL_LIN, 32'hA);
		rd_chk(OFS_BAND_ROT, 32'hA);
		rd_chk(OFS_BAND_LIN, 32'hA);
		rd_chk(OFS_REACH_PIN, 32'h0);
		rd_chk(6'h30, 32'h0);
		wr(OFS_LEVEL_ROT, 32'h4E20);
		rd_chk(OFS_LEVEL_ROT, 32'h2710);
		wr(OFS_BAND_LIN, 32'hC8);
		rd_chk(OFS_BAND_LIN, 32'h64);
		wr(OFS_LEVEL_ROT, 32'hA);
	endtask : t_defaults

	task automatic t_clamp();
		wr(OFS_HOLD_PIN, 32'h2);
		drv(16'hFFFB, 16'h0, 8'h04, 1'b0, 32'h1234);
		check(hold_active, 32'h1);
		check(effective_velocity_command, 32'h0);
		drv(16'hFFFB, 16'h0, 8'h04, 1'b0, 32'h9999);
		check(hold_position, 32'h1234);
		drv(16'h000A, 16'h0, 8'h04, 1'b0, 32'h9999);
		check(hold_active, 32'h1);
		drv(16'h000B, 16'h0, 8'h04, 1'b0, 32'h9999);
		check(hold_active, 32'h0);
		check(effective_velocity_command, 32'hB);
		drv(16'h0005, 16'h0, 8'h01, 1'b0, 32'h0);
		check(hold_active, 32'h0);
		drv(16'h0005, 16'h0, 8'h00, 1'b0, 32'h0);
		check(hold_active, 32'h0);
		check(effective_velocity_command, 32'h5);
	endtask : t_clamp

	task automatic t_modes();
		logic       ok;
		logic [3:0] m;
		for (int i = 0; i < 32; i++) begin
			m = i[4:1];
			ok = (m inside {4'h0, 4'h3, 4'h5}) || (!i[0] && m inside {4'h4, 4'h6, 4'hE})
				|| (i[0] && m inside {4'h7, 4'h9, 4'hC});
			wr(OFS_CONTROL, {28'h0, m});
			drv(16'h0, 16'h0, 8'h04, i[0], 32'h0);
			check(hold_active, {31'h0, ok});
		end
		wr(OFS_CONTROL, 32'h0);
	endtask : t_modes

	task automatic t_limits();
		wr(OFS_MAX_VEL, 32'h5);
		drv(16'h0007, 16'h0, 8'h04, 1'b0, 32'h0);
		check(hold_active, 32'h0);
		drv(16'hFFFC, 16'h0, 8'h04, 1'b0, 32'h0);
		check(hold_active, 32'h1);
		wr(OFS_MAX_VEL, 32'h1770);
		drv(16'h001E, 16'h0, 8'h04, 1'b0, 32'h0);
		wr(OFS_LEVEL_LIN, 32'h32);
		wr(OFS_CONTROL, 32'h10);
		settle();
		check(hold_active, 32'h1);
		wr(OFS_CONTROL, 32'h0);
		settle();
		check(hold_active, 32'h0);
	endtask : t_limits

	task automatic t_reach();
		wr(OFS_BAND_ROT, 32'h64);
		drv(16'h07D0, 16'h076C, 8'h00, 1'b0, 32'h0);
		check(general_outputs, 32'h1);
		drv(16'h07D0, 16'h076B, 8'h00, 1'b0, 32'h0);
		check(general_outputs, 32'h0);
		drv(16'h07D0, 16'hF7CC, 8'h00, 1'b0, 32'h0);
		check(general_outputs, 32'h1);
		drv(16'h07D0, 16'h0835, 8'h00, 1'b0, 32'h0);
		check(general_outputs, 32'h0);
		wr(OFS_REACH_PIN, 32'h2);
		drv(16'h07D0, 16'h07D0, 8'h00, 1'b0, 32'h0);
		check(general_outputs, 32'h4);
		rd_chk(OFS_STATUS, 32'h2);
		wr(OFS_BAND_LIN, 32'h5);
		wr(OFS_CONTROL, 32'h10);
		drv(16'h07D0, 16'h07C6, 8'h00, 1'b0, 32'h0);
		check(general_outputs, 32'h0);
		wr(OFS_CONTROL, 32'h0);
		settle();
		check(general_outputs, 32'h4);
	endtask : t_reach

	task automatic t_pulse();
		wr(OFS_CONTROL, 32'h1);
		i_motion_ctrl_model.pulses(3 * SPEED_W, 1'b0);
		#1;
		check(pulse_speed, 32'(SPEED_W));
		settle();
		check(pulse_position, 32'(3 * SPEED_W));
		i_motion_ctrl_model.pulses(1, 1'b1);
		settle();
		check(pulse_position, 32'(3 * SPEED_W - 1));
	endtask : t_pulse

	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		t_defaults();
		t_clamp();
		t_modes();
		t_limits();
		t_reach();
		t_pulse();
		wrap_up();
	end
endmodule : tb_zero_clamp_velocity_reach
